// ==== logic/aocr_pkg.sv ====
/*
 Package of register offsets, field positions, reset values and codes for the output configuration bank.
 Assumes an 8-bit register write/read port driven by the serial control port logic on the sample clock.
*/
package aocr_pkg;
	localparam logic [7:0] ADDR_GLOBAL_CLOCK   = 8'h09;
	localparam logic [7:0] ADDR_CLOCK_DIVIDE   = 8'h0B;
	localparam logic [7:0] ADDR_TEST_PATTERN   = 8'h0D;
	localparam logic [7:0] ADDR_SELF_TEST      = 8'h0E;
	localparam logic [7:0] ADDR_OUTPUT_FORMAT  = 8'h14;
	localparam logic [7:0] ADDR_PHASE_DELAY    = 8'h16;
	localparam logic [7:0] ADDR_DCLK_DELAY     = 8'h17;
	localparam logic [7:0] ADDR_REF_SELECT     = 8'h18;

	localparam logic [7:0] RST_GLOBAL_CLOCK  = 8'h01;
	localparam logic [7:0] RST_CLOCK_DIVIDE  = 8'h00;
	localparam logic [7:0] RST_TEST_PATTERN  = 8'h00;
	localparam logic [7:0] RST_SELF_TEST     = 8'h04;
	localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h00;
	localparam logic [7:0] RST_PHASE_DELAY   = 8'h00;
	localparam logic [7:0] RST_DCLK_DELAY    = 8'h00;
	localparam logic [7:0] RST_REF_SELECT    = 8'hC0;

	localparam int DATA_W = 16;

	localparam int POS_DCS_ENABLE    = 0;
	localparam int POS_PRBS_LONG_RST = 5;
	localparam int POS_PRBS_SHORT_RST= 4;
	localparam int POS_INVERT        = 2;
	localparam int POS_OUT_DISABLE   = 4;
	localparam int POS_OUT_TYPE      = 6;
	localparam int POS_DRIVE         = 7;
	localparam int POS_DCLK_INVERT   = 7;
	localparam int POS_SELF_TEST_EN  = 0;
	localparam int POS_REF_LEVEL     = 6;

	localparam logic [2:0] TM_OFF       = 3'h0;
	localparam logic [2:0] TM_MID       = 3'h1;
	localparam logic [2:0] TM_POS_FS    = 3'h2;
	localparam logic [2:0] TM_NEG_FS    = 3'h3;
	localparam logic [2:0] TM_CHECKER   = 3'h4;
	localparam logic [2:0] TM_PRBS_LONG = 3'h5;
	localparam logic [2:0] TM_PRBS_SHORT= 3'h6;
	localparam logic [2:0] TM_TOGGLE    = 3'h7;

	localparam logic [1:0] FMT_TWOS = 2'h1;
	localparam logic [1:0] FMT_GRAY = 2'h2;

	localparam logic [22:0] PRBS_LONG_SEED  = 23'h7FFFFF;
	localparam logic [8:0]  PRBS_SHORT_SEED = 9'h1FF;
	localparam logic [DATA_W-1:0] MID_CODE  = 16'h8000;
	localparam logic [DATA_W-1:0] POS_CODE  = 16'hFFFF;
	localparam logic [DATA_W-1:0] NEG_CODE  = 16'h0000;
	localparam logic [DATA_W-1:0] CHECK_A   = 16'hAAAA;

	localparam int DCLK_RANGE_PS = 2500;
	localparam int DCLK_STEPS    = 31;
	localparam logic [4:0] DCLK_MAX_CODE = 5'h1F;

	typedef enum logic [2:0] {
		AOCR_DIV_IDLE = 3'b001,
		AOCR_DIV_HIGH = 3'b010,
		AOCR_DIV_LOW  = 3'b100
	} aocr_div_state_t;
endpackage

// ==== logic/aocr_clock_if.sv ====
/*
 Interface carrying clock divider settings from the register bank to the divider.
 Assumes both ends sit on the same sample clock.
*/
interface aocr_clock_if;
	logic [2:0] divide_code;
	logic [2:0] phase_code;
	logic       sample_enable;
	modport bank (output divide_code, output phase_code, input sample_enable);
	modport divider (input divide_code, input phase_code, output sample_enable);
endinterface

// ==== logic/aocr_clock_divider.sv ====
/*
 Integer clock divider with a whole-cycle start delay, producing one sample enable per divided period.
 Assumes clk is the input clock and the interface comes from the register bank.
*/
module aocr_clock_divider (
	input  wire logic      clk,
	input  wire logic      resetn,
	input  wire logic      clk_en,
	aocr_clock_if.divider  cfg
);
	aocr_pkg::aocr_div_state_t state;
	logic [2:0] count;
	logic [2:0] delay_count;
	logic [2:0] last_div;
	logic [2:0] last_phase;

	// Any change of divide or phase restarts through the delay stage.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state         <= aocr_pkg::AOCR_DIV_IDLE;
			count         <= 3'h0;
			delay_count   <= 3'h0;
			last_div      <= 3'h0;
			last_phase    <= 3'h0;
			cfg.sample_enable <= 1'b0;
		end else if (clk_en) begin
			last_div   <= cfg.divide_code;
			last_phase <= cfg.phase_code;
			cfg.sample_enable <= 1'b0;
			if (last_div != cfg.divide_code || last_phase != cfg.phase_code) begin
				state       <= aocr_pkg::AOCR_DIV_IDLE;
				delay_count <= 3'h0;
			end else begin
				case (state)
				aocr_pkg::AOCR_DIV_IDLE: begin
					// Phase code N holds off the divider by N whole input cycles.
					if (delay_count == cfg.phase_code) begin
						state <= aocr_pkg::AOCR_DIV_HIGH;
						count <= 3'h0;
					end else begin
						delay_count <= delay_count + 3'h1;
					end
				end
				aocr_pkg::AOCR_DIV_HIGH: begin
					// Code 0 passes every cycle; code N yields one enable per N+1 cycles.
					cfg.sample_enable <= 1'b1;
					count <= 3'h0;
					if (cfg.divide_code != 3'h0) begin
						state <= aocr_pkg::AOCR_DIV_LOW;
					end
				end
				aocr_pkg::AOCR_DIV_LOW: begin
					if (count == cfg.divide_code - 3'h1) begin
						state <= aocr_pkg::AOCR_DIV_HIGH;
					end else begin
						count <= count + 3'h1;
					end
				end
				default: begin
					state <= aocr_pkg::AOCR_DIV_IDLE;
				end
				endcase
			end
		end
	end
endmodule

// ==== logic/aocr_bank.sv ====
/*
 Output configuration register bank: clocking control, test patterns, output format and data clock delay.
 Assumes the serial control port delivers single-cycle write and read strobes on clk.
*/
// What this block does
// - Three-bit clock divide; zero passes input clock, larger codes divide more.
// - Three-bit phase field delays divider start by zero to seven input cycles.
// - Test mode codes select off, midscale, full scales, checkerboard, word toggle.
// - Codes 101 and 110 give long and short PRBS; reset bits reseed them.
// - Format 00 or 11 offset binary, 01 twos complement, 10 gray; invert bit.
// - Five-bit data clock delay equals value times 2500 ps over 31.
// - Any nonzero test mode replaces converted samples on the outputs.
module aocr_bank (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic [15:0] sample_in,
	output logic [7:0]       reg_rdata,
	output logic [15:0]      data_out,
	output logic             sample_valid,
	output logic             dcs_active,
	output logic             output_disable,
	output logic             output_type_lvds,
	output logic             drive_reduced,
	output logic             output_data_clock_invert,
	output logic [11:0]      output_data_clock_delay_ps,
	output logic [1:0]       reference_level,
	output logic             self_test_enable
);
	logic [7:0] global_clock_control;
	logic [7:0] clock_divider_ratio;
	logic [7:0] output_test_pattern;
	logic [7:0] self_test_control;
	logic [7:0] output_format_control;
	logic [7:0] clock_phase_delay;
	logic [7:0] data_clock_out_delay;
	logic [7:0] reference_level_select;
	logic [22:0] prbs_long_pattern;
	logic [8:0]  prbs_short_pattern;
	logic        toggle_phase;
	logic [15:0] next_data;
	logic [15:0] coded;
	logic [15:0] test_word;
	logic [15:0] prbs_long_word;
	logic [15:0] prbs_short_word;
	logic [2:0]  mode;

	aocr_clock_if clk_cfg ();

	assign clk_cfg.divide_code = clock_divider_ratio[2:0];
	assign clk_cfg.phase_code  = clock_phase_delay[2:0];
	assign mode                = output_test_pattern[2:0];

	aocr_clock_divider u_divider (
		.clk    (clk),
		.resetn (resetn),
		.clk_en (clk_en),
		.cfg    (clk_cfg.divider)
	);

	// Writes to unmapped offsets are dropped, and every field keeps its value while clk_en is low.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			global_clock_control   <= aocr_pkg::RST_GLOBAL_CLOCK;
			clock_divider_ratio    <= aocr_pkg::RST_CLOCK_DIVIDE;
			output_test_pattern    <= aocr_pkg::RST_TEST_PATTERN;
			self_test_control      <= aocr_pkg::RST_SELF_TEST;
			output_format_control  <= aocr_pkg::RST_OUTPUT_FORMAT;
			clock_phase_delay      <= aocr_pkg::RST_PHASE_DELAY;
			data_clock_out_delay   <= aocr_pkg::RST_DCLK_DELAY;
			reference_level_select <= aocr_pkg::RST_REF_SELECT;
		end else if (clk_en && reg_write) begin
			case (reg_addr)
			aocr_pkg::ADDR_GLOBAL_CLOCK:  global_clock_control   <= reg_wdata;
			aocr_pkg::ADDR_CLOCK_DIVIDE:  clock_divider_ratio    <= reg_wdata;
			aocr_pkg::ADDR_TEST_PATTERN:  output_test_pattern    <= reg_wdata;
			aocr_pkg::ADDR_SELF_TEST:     self_test_control      <= reg_wdata;
			aocr_pkg::ADDR_OUTPUT_FORMAT: output_format_control  <= reg_wdata;
			aocr_pkg::ADDR_PHASE_DELAY:   clock_phase_delay      <= reg_wdata;
			aocr_pkg::ADDR_DCLK_DELAY:    data_clock_out_delay   <= reg_wdata;
			aocr_pkg::ADDR_REF_SELECT:    reference_level_select <= reg_wdata;
			default: begin
			end
			endcase
		end
	end

	// Reads of unmapped offsets return zero, and the last read value stands until the next read.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (clk_en && reg_read) begin
			case (reg_addr)
			aocr_pkg::ADDR_GLOBAL_CLOCK:  reg_rdata <= global_clock_control;
			aocr_pkg::ADDR_CLOCK_DIVIDE:  reg_rdata <= clock_divider_ratio;
			aocr_pkg::ADDR_TEST_PATTERN:  reg_rdata <= output_test_pattern;
			aocr_pkg::ADDR_SELF_TEST:     reg_rdata <= self_test_control;
			aocr_pkg::ADDR_OUTPUT_FORMAT: reg_rdata <= output_format_control;
			aocr_pkg::ADDR_PHASE_DELAY:   reg_rdata <= clock_phase_delay;
			aocr_pkg::ADDR_DCLK_DELAY:    reg_rdata <= data_clock_out_delay;
			aocr_pkg::ADDR_REF_SELECT:    reg_rdata <= reference_level_select;
			default:                      reg_rdata <= 8'h00;
			endcase
		end
	end

	// Each generator advances once per sample; its reset bit holds it at the seed.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prbs_long_pattern <= aocr_pkg::PRBS_LONG_SEED;
		end else if (clk_en) begin
			if (output_test_pattern[aocr_pkg::POS_PRBS_LONG_RST]) begin
				prbs_long_pattern <= aocr_pkg::PRBS_LONG_SEED;
			end else if (clk_cfg.sample_enable) begin
				prbs_long_pattern <= {prbs_long_pattern[21:0], prbs_long_pattern[22] ^ prbs_long_pattern[17]};
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prbs_short_pattern <= aocr_pkg::PRBS_SHORT_SEED;
		end else if (clk_en) begin
			if (output_test_pattern[aocr_pkg::POS_PRBS_SHORT_RST]) begin
				prbs_short_pattern <= aocr_pkg::PRBS_SHORT_SEED;
			end else if (clk_cfg.sample_enable) begin
				prbs_short_pattern <= {prbs_short_pattern[7:0], prbs_short_pattern[8] ^ prbs_short_pattern[4]};
			end
		end
	end

	// Checkerboard and word toggle both follow this phase, which flips on every sample.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			toggle_phase <= 1'b0;
		end else if (clk_en && clk_cfg.sample_enable) begin
			toggle_phase <= ~toggle_phase;
		end
	end

	assign prbs_long_word  = prbs_long_pattern[15:0];
	assign prbs_short_word = {prbs_short_pattern[6:0], prbs_short_pattern};

	// Test words are offset-binary patterns that bypass the format coding; the invert bit still applies to them.
	always_comb begin
		case (mode)
		aocr_pkg::TM_MID:        test_word = aocr_pkg::MID_CODE;
		aocr_pkg::TM_POS_FS:     test_word = aocr_pkg::POS_CODE;
		aocr_pkg::TM_NEG_FS:     test_word = aocr_pkg::NEG_CODE;
		aocr_pkg::TM_CHECKER:    test_word = toggle_phase ? ~aocr_pkg::CHECK_A : aocr_pkg::CHECK_A;
		aocr_pkg::TM_PRBS_LONG:  test_word = prbs_long_word;
		aocr_pkg::TM_PRBS_SHORT: test_word = prbs_short_word;
		aocr_pkg::TM_TOGGLE:     test_word = toggle_phase ? aocr_pkg::POS_CODE : aocr_pkg::NEG_CODE;
		default:                 test_word = sample_in;
		endcase
	end

	// Samples are offset binary; other formats are derived from that.
	always_comb begin
		case (output_format_control[1:0])
		aocr_pkg::FMT_TWOS: coded = {~sample_in[15], sample_in[14:0]};
		aocr_pkg::FMT_GRAY: coded = sample_in ^ {1'b0, sample_in[15:1]};
		default:            coded = sample_in;
		endcase
		next_data = (mode != aocr_pkg::TM_OFF) ? test_word : coded;
		if (output_format_control[aocr_pkg::POS_INVERT]) begin
			next_data = ~next_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_out     <= 16'h0000;
			sample_valid <= 1'b0;
		end else if (clk_en) begin
			sample_valid <= clk_cfg.sample_enable;
			if (clk_cfg.sample_enable) begin
				data_out <= next_data;
			end
		end
	end

	// A divide ratio above one forces the stabiliser on, whatever its enable bit holds.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dcs_active <= aocr_pkg::RST_GLOBAL_CLOCK[aocr_pkg::POS_DCS_ENABLE];
		end else if (clk_en) begin
			dcs_active <= global_clock_control[aocr_pkg::POS_DCS_ENABLE] || (clock_divider_ratio[2:0] != 3'h0);
		end
	end

	// The data clock delay is rounded to the nearest picosecond.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			output_data_clock_delay_ps <= 12'h000;
		end else if (clk_en) begin
			output_data_clock_delay_ps <= 12'((int'(data_clock_out_delay[4:0]) * aocr_pkg::DCLK_RANGE_PS
				+ aocr_pkg::DCLK_STEPS / 2) / aocr_pkg::DCLK_STEPS);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			output_disable           <= 1'b0;
			output_type_lvds         <= 1'b0;
			drive_reduced            <= 1'b0;
			output_data_clock_invert <= 1'b0;
			reference_level          <= aocr_pkg::RST_REF_SELECT[aocr_pkg::POS_REF_LEVEL +: 2];
			self_test_enable         <= aocr_pkg::RST_SELF_TEST[aocr_pkg::POS_SELF_TEST_EN];
		end else if (clk_en) begin
			output_disable           <= output_format_control[aocr_pkg::POS_OUT_DISABLE];
			output_type_lvds         <= output_format_control[aocr_pkg::POS_OUT_TYPE];
			drive_reduced            <= output_format_control[aocr_pkg::POS_DRIVE];
			output_data_clock_invert <= clock_phase_delay[aocr_pkg::POS_DCLK_INVERT];
			reference_level          <= reference_level_select[aocr_pkg::POS_REF_LEVEL +: 2];
			self_test_enable         <= self_test_control[aocr_pkg::POS_SELF_TEST_EN];
		end
	end
endmodule

// ==== dv/aocr_host_model.sv ====
/*
 Host controller model that writes and reads the bank's registers.
 Assumes the bank takes one request at a rising clk edge and has read data out just after that same edge.
*/
module aocr_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_write,
	output logic            reg_read,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {reg_write, reg_read, reg_addr, reg_wdata} = 18'h0;
	// Released address and data show the inverse so stale values are never mistaken for live ones.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		{reg_write, reg_addr, reg_wdata} = {1'b1, a, v};
		@(posedge clk);
		#1;
		{reg_write, reg_addr, reg_wdata} = {1'b0, ~a, ~v};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		{reg_read, reg_addr} = {1'b1, a};
		@(posedge clk);
		#1;
		{reg_read, reg_addr} = {1'b0, ~a};
		v = reg_rdata;
	endtask
endmodule

// ==== dv/aocr_bank_chk.sv ====
/*
 Concurrent checks on the output configuration bank's ports.
 Assumes one sample clock and the bank's active-low asynchronous reset.
*/
module aocr_bank_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        clk_en,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic [15:0] data_out,
	input wire logic        sample_valid,
	input wire logic        dcs_active,
	input wire logic [11:0] output_data_clock_delay_ps
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// A taken write plus two enabled edges, after which derived outputs show it.
	sequence s_wr(logic [7:0] a, logic c);
		clk_en && reg_write && reg_addr == a && c ##1 clk_en [*2];
	endsequence
	sequence s_word(logic [15:0] e);
		sample_valid && (data_out == e || data_out == ~e);
	endsequence
	property p_dcs_forced;
		s_wr(aocr_pkg::ADDR_CLOCK_DIVIDE, reg_wdata[2:0] != 3'h0) |=> dcs_active;
	endproperty
	a_dcs_forced: assert property (p_dcs_forced) else $error("stabiliser not forced");
	property p_div_one;
		s_wr(aocr_pkg::ADDR_CLOCK_DIVIDE, reg_wdata[2:0] == 3'h0) |-> ##[1:12] sample_valid [*4];
	endproperty
	a_div_one: assert property (p_div_one) else $error("undivided clock not every cycle");
	property p_pos_fs;
		s_wr(aocr_pkg::ADDR_TEST_PATTERN, reg_wdata[2:0] == aocr_pkg::TM_POS_FS) |-> ##[1:20] s_word(16'hFFFF);
	endproperty
	a_pos_fs: assert property (p_pos_fs) else $error("full scale word missing");
	property p_prbs_seed;
		s_wr(aocr_pkg::ADDR_TEST_PATTERN, reg_wdata == 8'h25) |-> ##[1:20] s_word(16'hFFFF);
	endproperty
	a_prbs_seed: assert property (p_prbs_seed) else $error("held sequence not at seed");
	property p_dclk_delay;
		s_wr(aocr_pkg::ADDR_DCLK_DELAY, 1'b1) |=> output_data_clock_delay_ps ==
			12'((int'($past(reg_wdata, 3) & 8'h1F) * aocr_pkg::DCLK_RANGE_PS + aocr_pkg::DCLK_STEPS / 2)
			/ aocr_pkg::DCLK_STEPS);
	endproperty
	a_dclk_delay: assert property (p_dclk_delay) else $error("data clock delay wrong");
	property p_rd_unmapped;
		clk_en && reg_read && !(reg_addr inside {8'h09, 8'h0B, 8'h0D, 8'h0E, 8'h14, 8'h16, 8'h17, 8'h18})
			|=> reg_rdata == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	property p_hold_word;
		!sample_valid |-> $stable(data_out);
	endproperty
	a_hold_word: assert property (p_hold_word) else $error("output word changed without sample");
	property p_freeze;
		!clk_en |=> $stable(reg_rdata) && $stable(dcs_active);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule

bind aocr_bank aocr_bank_chk chk (.clk, .resetn, .clk_en, .reg_write, .reg_read, .reg_addr, .reg_wdata,
	.reg_rdata, .data_out, .sample_valid, .dcs_active, .output_data_clock_delay_ps);

// ==== dv/tb_aocr_bank.sv ====
/*
 Self-checking bench of the output configuration bank through its register port.
 Assumes the host model drives the port and the checker is bound to the bank.
*/
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb_aocr_bank;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] S = 16'h1234;
	localparam logic [7:0] ADRS [9] = '{8'h09, 8'h0B, 8'h0D, 8'h0E, 8'h14, 8'h16, 8'h17, 8'h18, 8'h0A};
	localparam logic [7:0] RSTV [9] = '{8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00};
	localparam logic [7:0] DIVS [3] = '{8'h03, 8'h00, 8'h07};
	localparam logic [7:0] PATS [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07};
	localparam logic [15:0] PEXP [5] = '{16'h8000, 16'hFFFF, 16'h0000, 16'hAAAA, 16'hFFFF};
	localparam logic [7:0] FMTS [5] = '{8'h00, 8'h03, 8'h01, 8'h02, 8'h04};
	localparam logic [15:0] FEXP [5] = '{S, S, S ^ 16'h8000, S ^ (S >> 1), ~S};
	localparam logic [7:0] DLYS [4] = '{8'h01, 8'h02, 8'h1E, 8'h1F};
	localparam logic [11:0] DLYX [4] = '{12'h051, 12'h0A1, 12'h973, 12'h9C4};
	logic        clk, resetn, clk_en, reg_write, reg_read, sample_valid, dcs_active;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [11:0] dly_ps;
	logic [15:0] data_out, d0, smp;
	logic        od, ot, dr, dci, ste;
	logic [1:0]  rl;
	int          err_count, n_compared, w0, w7, g, k;
	aocr_bank uut (.clk, .resetn, .clk_en, .reg_write, .reg_read, .reg_addr, .reg_wdata, .sample_in(smp),
		.reg_rdata, .data_out, .sample_valid, .dcs_active, .output_disable(od), .output_type_lvds(ot),
		.drive_reduced(dr), .output_data_clock_invert(dci), .output_data_clock_delay_ps(dly_ps),
		.reference_level(rl), .self_test_enable(ste));
	aocr_host_model h (.clk, .reg_rdata, .reg_write, .reg_read, .reg_addr, .reg_wdata);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("TB: %0d compared, %0d errors", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// Cycles until the next sample, then the spacing to the one after.
	task automatic gap(output int w, output int n);
		#1;
		w = 0;
		while (sample_valid !== 1'b1 && w < 40) begin
			settle(1);
			w++;
		end
		n = 0;
		do begin
			settle(1);
			n++;
		end while (sample_valid !== 1'b1 && n < 40);
	endtask
	initial begin
		#40000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		smp = S;
		settle(16);
		resetn = 1'b1;
		foreach (ADRS[i]) begin
			h.rd(ADRS[i], d);
			`CHK(d, RSTV[i])
		end
		`CHK(dcs_active, 1'b1)
		h.wr(aocr_pkg::ADDR_GLOBAL_CLOCK, 8'h00);
		foreach (DIVS[i]) begin
			h.wr(aocr_pkg::ADDR_CLOCK_DIVIDE, DIVS[i]);
			settle(3);
			`CHK(dcs_active, DIVS[i] != 8'h00)
			gap(w0, g);
			`CHK(g, DIVS[i] + 1)
		end
		h.wr(aocr_pkg::ADDR_PHASE_DELAY, 8'h07);
		settle(16);
		gap(w7, g);
		h.wr(aocr_pkg::ADDR_PHASE_DELAY, 8'h00);
		settle(16);
		gap(w0, g);
		`CHK((w7 - w0 + 8) % 8, 7)
		h.wr(aocr_pkg::ADDR_CLOCK_DIVIDE, 8'h00);
		foreach (PATS[i]) begin
			h.wr(aocr_pkg::ADDR_TEST_PATTERN, PATS[i]);
			settle(5);
			d0 = data_out;
			settle(1);
			`CHK(d0 === PEXP[i] || (PATS[i] > 8'h03 && d0 === ~PEXP[i]), 1'b1)
			if (PATS[i] > 8'h03)
				`CHK(data_out ^ d0, 16'hFFFF)
		end
		for (int i = 0; i < 2; i++) begin
			h.wr(aocr_pkg::ADDR_TEST_PATTERN, i ? 8'h16 : 8'h25);
			settle(5);
			`CHK(data_out, 16'hFFFF)
			h.wr(aocr_pkg::ADDR_TEST_PATTERN, i ? 8'h06 : 8'h05);
			settle(5);
			d0 = data_out;
			k = 0;
			repeat (24) begin
				settle(1);
				k += int'(data_out !== d0);
			end
			`CHK(k > 0, 1'b1)
		end
		h.wr(aocr_pkg::ADDR_TEST_PATTERN, 8'h00);
		foreach (FMTS[i]) begin
			h.wr(aocr_pkg::ADDR_OUTPUT_FORMAT, FMTS[i]);
			settle(5);
			`CHK(data_out, FEXP[i])
		end
		smp = 16'hF0F1;
		settle(3);
		`CHK(data_out, 16'h0F0E)
		h.wr(aocr_pkg::ADDR_TEST_PATTERN, 8'h01);
		settle(5);
		`CHK(data_out, ~aocr_pkg::MID_CODE)
		foreach (DLYS[i]) begin
			h.wr(aocr_pkg::ADDR_DCLK_DELAY, DLYS[i]);
			settle(3);
			`CHK(dly_ps, DLYX[i])
		end
		clk_en = 1'b0;
		h.wr(aocr_pkg::ADDR_REF_SELECT, 8'h40);
		clk_en = 1'b1;
		h.rd(aocr_pkg::ADDR_REF_SELECT, d);
		`CHK(d, 8'hC0)
		h.wr(aocr_pkg::ADDR_REF_SELECT, 8'h40);
		h.wr(aocr_pkg::ADDR_SELF_TEST, 8'h05);
		h.wr(aocr_pkg::ADDR_OUTPUT_FORMAT, 8'hD0);
		h.wr(aocr_pkg::ADDR_PHASE_DELAY, 8'h80);
		settle(3);
		`CHK({od, ot, dr, dci, ste, rl}, 7'h7D)
		resetn = 1'b0;
		settle(2);
		resetn = 1'b1;
		h.rd(aocr_pkg::ADDR_REF_SELECT, d);
		`CHK(d, 8'hC0)
		`CHK({od, ot, dr, dci, ste, rl}, 7'h03)
		tally_and_finish();
	end
endmodule
